// ### design/pcfg_pkg.sv
/*
  pcfg_pkg: register indices, implemented-bit masks, reset values and
  field limits for the port and analog-pin configuration bank.
  Assumes a 32-bit AXI4-Lite bus; byte address is four times the index.
*/
package pcfg_pkg;

  localparam int PCFG_NREG = 15;
  localparam int PCFG_NPIN = 5;
  localparam int PCFG_AW   = 18;

  // register indices (byte address = index * 4)
  localparam logic [15:0] PCFG_IDX_PORT2_LATCH   = 16'hFF02;
  localparam logic [15:0] PCFG_IDX_PORT6_LATCH   = 16'hFF06;
  localparam logic [15:0] PCFG_IDX_PORT7_LATCH   = 16'hFF07;
  localparam logic [15:0] PCFG_IDX_PORT12_LATCH  = 16'hFF0C;
  localparam logic [15:0] PCFG_IDX_PORT2_DIR     = 16'hFF22;
  localparam logic [15:0] PCFG_IDX_PORT4_DIR     = 16'hFF24;
  localparam logic [15:0] PCFG_IDX_PORT6_DIR     = 16'hFF26;
  localparam logic [15:0] PCFG_IDX_PORT7_DIR     = 16'hFF27;
  localparam logic [15:0] PCFG_IDX_CHAN_SEL      = 16'hFF29;
  localparam logic [15:0] PCFG_IDX_PORT12_DIR    = 16'hFF2C;
  localparam logic [15:0] PCFG_IDX_PORT14_DIR    = 16'hFF2E;
  localparam logic [15:0] PCFG_IDX_PIN_CFG       = 16'hFF2F;
  localparam logic [15:0] PCFG_IDX_PORT4_PULLUP  = 16'hFF34;
  localparam logic [15:0] PCFG_IDX_PORT7_PULLUP  = 16'hFF37;
  localparam logic [15:0] PCFG_IDX_PORT14_PULLUP = 16'hFF3E;

  // slot numbers inside the register array
  localparam int PCFG_R_PORT2_LATCH   = 0;
  localparam int PCFG_R_PORT6_LATCH   = 1;
  localparam int PCFG_R_PORT7_LATCH   = 2;
  localparam int PCFG_R_PORT12_LATCH  = 3;
  localparam int PCFG_R_PORT2_DIR     = 4;
  localparam int PCFG_R_PORT4_DIR     = 5;
  localparam int PCFG_R_PORT6_DIR     = 6;
  localparam int PCFG_R_PORT7_DIR     = 7;
  localparam int PCFG_R_CHAN_SEL      = 8;
  localparam int PCFG_R_PORT12_DIR    = 9;
  localparam int PCFG_R_PORT14_DIR    = 10;
  localparam int PCFG_R_PIN_CFG       = 11;
  localparam int PCFG_R_PORT4_PULLUP  = 12;
  localparam int PCFG_R_PORT7_PULLUP  = 13;
  localparam int PCFG_R_PORT14_PULLUP = 14;

  // implemented (writable) bits
  localparam logic [7:0] PCFG_MASK_PORT2_LATCH   = 8'h1F;
  localparam logic [7:0] PCFG_MASK_PORT6_LATCH   = 8'h03;
  localparam logic [7:0] PCFG_MASK_PORT7_LATCH   = 8'h01;
  localparam logic [7:0] PCFG_MASK_PORT12_LATCH  = 8'h07;
  localparam logic [7:0] PCFG_MASK_PORT2_DIR     = 8'h1F;
  localparam logic [7:0] PCFG_MASK_PORT4_DIR     = 8'h03;
  localparam logic [7:0] PCFG_MASK_PORT6_DIR     = 8'h0F;
  localparam logic [7:0] PCFG_MASK_PORT7_DIR     = 8'h3F;
  localparam logic [7:0] PCFG_MASK_CHAN_SEL      = 8'h07;
  localparam logic [7:0] PCFG_MASK_PORT12_DIR    = 8'h1F;
  localparam logic [7:0] PCFG_MASK_PORT14_DIR    = 8'h01;
  localparam logic [7:0] PCFG_MASK_PIN_CFG       = 8'h07;
  localparam logic [7:0] PCFG_MASK_PORT4_PULLUP  = 8'h00;
  localparam logic [7:0] PCFG_MASK_PORT7_PULLUP  = 8'h01;
  localparam logic [7:0] PCFG_MASK_PORT14_PULLUP = 8'h00;

  // reset values; fixed bits keep them forever
  localparam logic [7:0] PCFG_RST_LATCH  = 8'h00;
  localparam logic [7:0] PCFG_RST_DIR    = 8'hFF;
  localparam logic [7:0] PCFG_RST_ANALOG = 8'h00;
  localparam logic [7:0] PCFG_RST_PULLUP = 8'h00;

  localparam logic [15:0] PCFG_IDX_TABLE [PCFG_NREG] = '{
    PCFG_IDX_PORT2_LATCH, PCFG_IDX_PORT6_LATCH, PCFG_IDX_PORT7_LATCH,
    PCFG_IDX_PORT12_LATCH, PCFG_IDX_PORT2_DIR, PCFG_IDX_PORT4_DIR,
    PCFG_IDX_PORT6_DIR, PCFG_IDX_PORT7_DIR, PCFG_IDX_CHAN_SEL,
    PCFG_IDX_PORT12_DIR, PCFG_IDX_PORT14_DIR, PCFG_IDX_PIN_CFG,
    PCFG_IDX_PORT4_PULLUP, PCFG_IDX_PORT7_PULLUP, PCFG_IDX_PORT14_PULLUP};

  localparam logic [7:0] PCFG_MASK_TABLE [PCFG_NREG] = '{
    PCFG_MASK_PORT2_LATCH, PCFG_MASK_PORT6_LATCH, PCFG_MASK_PORT7_LATCH,
    PCFG_MASK_PORT12_LATCH, PCFG_MASK_PORT2_DIR, PCFG_MASK_PORT4_DIR,
    PCFG_MASK_PORT6_DIR, PCFG_MASK_PORT7_DIR, PCFG_MASK_CHAN_SEL,
    PCFG_MASK_PORT12_DIR, PCFG_MASK_PORT14_DIR, PCFG_MASK_PIN_CFG,
    PCFG_MASK_PORT4_PULLUP, PCFG_MASK_PORT7_PULLUP,
    PCFG_MASK_PORT14_PULLUP};

  localparam logic [7:0] PCFG_RST_TABLE [PCFG_NREG] = '{
    PCFG_RST_LATCH, PCFG_RST_LATCH, PCFG_RST_LATCH, PCFG_RST_LATCH,
    PCFG_RST_DIR, PCFG_RST_DIR, PCFG_RST_DIR, PCFG_RST_DIR,
    PCFG_RST_ANALOG, PCFG_RST_DIR, PCFG_RST_DIR, PCFG_RST_ANALOG,
    PCFG_RST_PULLUP, PCFG_RST_PULLUP, PCFG_RST_PULLUP};

  // field limits
  localparam logic [2:0] PCFG_CHAN_LAST = 3'h4;
  localparam logic [2:0] PCFG_PIN_LAST  = 3'h5;

  localparam logic [1:0] PCFG_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PCFG_RESP_SLVERR = 2'h2;

endpackage

// ### design/pcfg_pin_decode.sv
/*
  pcfg_pin_decode: turns the channel-select and pin-config codes into
  registered per-pin analog flags and a one-hot converter input select.
  Assumes codes come from registers on the same clock.
*/
`timescale 1ns/1ns
module pcfg_pin_decode #(
  parameter int NPIN = 5
) (
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic [2:0]      chan_code,
  input  wire logic [2:0]      pin_code,
  output logic      [NPIN-1:0] analog_pin,
  output logic      [NPIN-1:0] chan_onehot,
  output logic                 chan_valid
);

  logic [NPIN-1:0] next_analog;
  logic [NPIN-1:0] next_onehot;
  logic            chan_ok;
  logic            pin_ok;

  assign chan_ok = chan_code <= pcfg_pkg::PCFG_CHAN_LAST;
  assign pin_ok  = pin_code <= pcfg_pkg::PCFG_PIN_LAST;

  // prohibited pin code keeps every pin analog, the harmless state
  for (genvar p = 0; p < NPIN; p++) begin : g_pin
    localparam logic [2:0] PIN = 3'(p);
    assign next_analog[p] = !pin_ok || (pin_code <= PIN);
    assign next_onehot[p] = chan_ok && (chan_code == PIN);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_pin <= '1;
    end else begin
      analog_pin <= next_analog;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_onehot <= {{(NPIN-1){1'b0}}, 1'b1};
      chan_valid  <= 1'b1;
    end else begin
      chan_onehot <= next_onehot;
      chan_valid  <= chan_ok;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_pin_mask_map: assert property (
    pin_ok |=> analog_pin ==
      ~NPIN'((6'h01 << $past(pin_code)) - 6'h01))
    else $error("analog pin mask does not match config code");

  a_chan_route: assert property (
    chan_ok |=> chan_valid && chan_onehot ==
      NPIN'(6'h01 << $past(chan_code)))
    else $error("legal channel code routed wrong input");

  a_chan_forbid: assert property (
    !chan_ok |=> !chan_valid && chan_onehot == '0)
    else $error("forbidden channel code still routes an input");

  a_pins_reset: assert property (
    $rose(aresetn) |-> analog_pin == '1)
    else $error("pins not analog after reset");

endmodule

// ### design/pcfg_regs.sv
/*
  pcfg_regs: AXI4-Lite register bank for port latches, port directions,
  pull-up options, analog channel select and analog/digital pin config.
  Assumes a single-master AXI4-Lite bus on aclk with 32-bit data; each
  register is one aligned word, data in the low byte.
*/
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ns
// Notes on behaviour
// - channel code 0..4 routes analog input 0..4; codes 5..7 are forbidden.
// - pin config n in 0..5 makes lowest n shared pins digital.
// - pin config resets to 00, all analog; bits 3..7 stay zero.
// - all direction registers reset to FF; port-2 direction bits 5..7 read one.
// - port-2 latch holds bits 0..4, resets to 00, upper bits zero.
// - after reset the five shared pins are analog inputs.
module pcfg_regs #(
  parameter int AW = pcfg_pkg::PCFG_AW
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]    s_axi_awprot,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic [2:0]    s_axi_arprot,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic [4:0]         port2_latch,
  output logic [1:0]         port6_latch,
  output logic               port7_latch,
  output logic [2:0]         port12_latch,
  output logic [4:0]         port2_direction,
  output logic [1:0]         port4_direction,
  output logic [3:0]         port6_direction,
  output logic [5:0]         port7_direction,
  output logic [4:0]         port12_direction,
  output logic               port14_direction,
  output logic               port7_pullup,
  output logic [4:0]         analog_pin,
  output logic [4:0]         analog_input_sel,
  output logic               analog_input_valid
);

  localparam int NREG = pcfg_pkg::PCFG_NREG;

  logic [7:0]      regs [NREG];
  logic            aw_held;
  logic            w_held;
  logic [15:0]     waddr_idx;
  logic [7:0]      wbyte;
  logic            wlane;
  logic            do_write;
  logic [NREG-1:0] wsel;
  logic [NREG-1:0] rsel;
  logic [15:0]     raddr_idx;
  logic [7:0]      next_rbyte;
  logic            rhit;

  // prot is accepted but not checked: the bank has no secure split
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign raddr_idx     = s_axi_araddr[17:2];

  // write address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      waddr_idx <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held   <= 1'b1;
      waddr_idx <= s_axi_awaddr[17:2];
    end else if (do_write) begin
      aw_held   <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      wbyte  <= '0;
      wlane  <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      wbyte  <= s_axi_wdata[7:0];
      wlane  <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      wsel[i] = waddr_idx == pcfg_pkg::PCFG_IDX_TABLE[i];
      rsel[i] = raddr_idx == pcfg_pkg::PCFG_IDX_TABLE[i];
    end
  end

  // one register per slot; fixed bits always reload their reset value
  for (genvar r = 0; r < NREG; r++) begin : g_reg
    localparam logic [7:0] MASK = pcfg_pkg::PCFG_MASK_TABLE[r];
    localparam logic [7:0] RST  = pcfg_pkg::PCFG_RST_TABLE[r];
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        regs[r] <= RST;
      end else if (do_write && wsel[r] && wlane) begin
        regs[r] <= (wbyte & MASK) | (RST & ~MASK);
      end
    end
  end

  // unmapped words, the absent ones included, answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pcfg_pkg::PCFG_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (|wsel) ? pcfg_pkg::PCFG_RESP_OKAY
                              : pcfg_pkg::PCFG_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_comb begin
    next_rbyte = '0;
    rhit       = |rsel;
    for (int i = 0; i < NREG; i++) begin
      if (rsel[i]) begin
        next_rbyte = next_rbyte | regs[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= pcfg_pkg::PCFG_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, next_rbyte};
      s_axi_rresp  <= rhit ? pcfg_pkg::PCFG_RESP_OKAY
                           : pcfg_pkg::PCFG_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // outputs carry implemented bits straight from the registers
  assign port2_latch      = regs[pcfg_pkg::PCFG_R_PORT2_LATCH][4:0];
  assign port6_latch      = regs[pcfg_pkg::PCFG_R_PORT6_LATCH][1:0];
  assign port7_latch      = regs[pcfg_pkg::PCFG_R_PORT7_LATCH][0];
  assign port12_latch     = regs[pcfg_pkg::PCFG_R_PORT12_LATCH][2:0];
  assign port2_direction  = regs[pcfg_pkg::PCFG_R_PORT2_DIR][4:0];
  assign port4_direction  = regs[pcfg_pkg::PCFG_R_PORT4_DIR][1:0];
  assign port6_direction  = regs[pcfg_pkg::PCFG_R_PORT6_DIR][3:0];
  assign port7_direction  = regs[pcfg_pkg::PCFG_R_PORT7_DIR][5:0];
  assign port12_direction = regs[pcfg_pkg::PCFG_R_PORT12_DIR][4:0];
  assign port14_direction = regs[pcfg_pkg::PCFG_R_PORT14_DIR][0];
  assign port7_pullup     = regs[pcfg_pkg::PCFG_R_PORT7_PULLUP][0];

  pcfg_pin_decode #(
    .NPIN        (pcfg_pkg::PCFG_NPIN)
  ) u_decode (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .chan_code   (regs[pcfg_pkg::PCFG_R_CHAN_SEL][2:0]),
    .pin_code    (regs[pcfg_pkg::PCFG_R_PIN_CFG][2:0]),
    .analog_pin  (analog_pin),
    .chan_onehot (analog_input_sel),
    .chan_valid  (analog_input_valid)
  );

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_write_ready;
    aw_held && w_held && !s_axi_bvalid;
  endsequence

  sequence s_read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_dir2_fixed: assert property (
    regs[pcfg_pkg::PCFG_R_PORT2_DIR][7:5] == 3'h7)
    else $error("port-2 direction upper bits not one");

  a_dir_reset: assert property (
    $rose(aresetn) |-> regs[pcfg_pkg::PCFG_R_PORT4_DIR] == 8'hFF &&
      regs[pcfg_pkg::PCFG_R_PORT14_DIR] == 8'hFF)
    else $error("direction registers not FF after reset");

  a_p2_upper_zero: assert property (
    regs[pcfg_pkg::PCFG_R_PORT2_LATCH][7:5] == 3'h0)
    else $error("port-2 latch upper bits not zero");

  a_analog_reset: assert property (
    $rose(aresetn) |-> regs[pcfg_pkg::PCFG_R_PIN_CFG] == 8'h00 &&
      regs[pcfg_pkg::PCFG_R_CHAN_SEL] == 8'h00)
    else $error("analog registers not 00 after reset");

  a_chan_upper_zero: assert property (
    regs[pcfg_pkg::PCFG_R_CHAN_SEL][7:3] == 5'h00 &&
      regs[pcfg_pkg::PCFG_R_PORT4_PULLUP] == 8'h00)
    else $error("unimplemented bits changed");

  a_write_resp: assert property (
    s_write_ready |=> s_axi_bvalid && !aw_held && !w_held)
    else $error("write not answered one cycle after both halves");

  a_read_resp: assert property (
    s_read_taken |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000)
    else $error("read not answered one cycle after address");

  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");

  a_pin_cfg_upper: assert property (
    regs[pcfg_pkg::PCFG_R_PIN_CFG][7:3] == 5'h00)
    else $error("pin config upper bits not zero");

  // checks one register with both fixed ones and writable bits
  a_write_store: assert property (
    s_write_ready ##0 (wlane && wsel[pcfg_pkg::PCFG_R_PORT7_DIR]) |=>
      regs[pcfg_pkg::PCFG_R_PORT7_DIR] ==
        (($past(wbyte) & pcfg_pkg::PCFG_MASK_PORT7_DIR) |
         (pcfg_pkg::PCFG_RST_DIR & ~pcfg_pkg::PCFG_MASK_PORT7_DIR)))
    else $error("port-7 direction write stored wrong value");

  a_lane_off: assert property (
    s_write_ready ##0 !wlane |=>
      $stable(regs[pcfg_pkg::PCFG_R_PORT2_LATCH]))
    else $error("write with low byte lane off changed a register");

endmodule

// ### test/tb_top.sv
/*
  tb_top: self-checking bench for the pcfg_regs register bank.
  Assumes pcfg_pkg is compiled first; drives AXI4-Lite as the master.
*/
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {
    logic [31:0] d;
    logic [1:0]  r;
  } pcfg_tb_rd_s;

  logic              aclk;
  logic              aresetn;
  logic [17:0]       s_axi_awaddr;
  logic [2:0]        s_axi_awprot;
  logic              s_axi_awvalid;
  logic              s_axi_awready;
  logic [31:0]       s_axi_wdata;
  logic [3:0]        s_axi_wstrb;
  logic              s_axi_wvalid;
  logic              s_axi_wready;
  logic [1:0]        s_axi_bresp;
  logic              s_axi_bvalid;
  logic              s_axi_bready;
  logic [17:0]       s_axi_araddr;
  logic [2:0]        s_axi_arprot;
  logic              s_axi_arvalid;
  logic              s_axi_arready;
  logic [31:0]       s_axi_rdata;
  logic [1:0]        s_axi_rresp;
  logic              s_axi_rvalid;
  logic              s_axi_rready;
  logic [4:0]        port2_latch;
  logic [1:0]        port6_latch;
  logic              port7_latch;
  logic [2:0]        port12_latch;
  logic [4:0]        port2_direction;
  logic [1:0]        port4_direction;
  logic [3:0]        port6_direction;
  logic [5:0]        port7_direction;
  logic [4:0]        port12_direction;
  logic              port14_direction;
  logic              port7_pullup;
  logic [4:0]        analog_pin;
  logic [4:0]        analog_input_sel;
  logic              analog_input_valid;
  logic [7:0]        sh [pcfg_pkg::PCFG_NREG];
  logic [1:0]        bq [$];
  pcfg_tb_rd_s       rq [$];
  int                bad_count;
  int                total_checks;

  pcfg_regs dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .port2_latch(port2_latch),
    .port6_latch(port6_latch), .port7_latch(port7_latch),
    .port12_latch(port12_latch), .port2_direction(port2_direction),
    .port4_direction(port4_direction), .port6_direction(port6_direction),
    .port7_direction(port7_direction),
    .port12_direction(port12_direction),
    .port14_direction(port14_direction), .port7_pullup(port7_pullup),
    .analog_pin(analog_pin), .analog_input_sel(analog_input_sel),
    .analog_input_valid(analog_input_valid)
  );

  always #5 aclk = ~aclk;

  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_bus(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_pin(input string nm, input logic [7:0] e,
                         input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // fixed bits keep their reset level whatever is written
  function automatic logic [7:0] stored(int i, logic [7:0] d);
    return (d & pcfg_pkg::PCFG_MASK_TABLE[i]) |
           (pcfg_pkg::PCFG_RST_TABLE[i] & ~pcfg_pkg::PCFG_MASK_TABLE[i]);
  endfunction

  // response notes are checked at the handshake edge
  always @(posedge aclk) begin
    pcfg_tb_rd_s e;
    logic [1:0]  eb;
    if (s_axi_bvalid === 1'b1 && s_axi_bready) begin
      eb = bq.pop_front();
      chk_bus("bresp", {30'h0, eb}, {30'h0, s_axi_bresp});
    end
    if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
      e = rq.pop_front();
      chk_bus("rdata", e.d, s_axi_rdata);
      chk_bus("rresp", {30'h0, e.r}, {30'h0, s_axi_rresp});
    end
  end

  task automatic wr(input logic [15:0] idx, input logic [7:0] d,
                    input logic [3:0] st, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    bq.push_back(er);
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_awprot  <= 3'($urandom);
    s_axi_wdata   <= {24'($urandom), d};
    s_axi_wstrb   <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    // a slow master lets the response stand a while
    repeat ($urandom % 3) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] idx, input logic [31:0] ed,
                    input logic [1:0] er);
    rq.push_back('{ed, er});
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arprot  <= 3'($urandom);
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    repeat ($urandom % 3) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr_slot(input int i, input logic [7:0] d);
    wr(pcfg_pkg::PCFG_IDX_TABLE[i], d, {3'($urandom), 1'b1},
       pcfg_pkg::PCFG_RESP_OKAY);
    sh[i] = stored(i, d);
  endtask

  task automatic read_all;
    for (int i = 0; i < pcfg_pkg::PCFG_NREG; i++) begin
      rd(pcfg_pkg::PCFG_IDX_TABLE[i], {24'h0, sh[i]},
         pcfg_pkg::PCFG_RESP_OKAY);
    end
  endtask

  task automatic check_ports;
    logic [2:0] c;
    logic [2:0] n;
    c = sh[8][2:0];
    n = sh[11][2:0];
    @(posedge aclk);
    chk_pin("port2_latch", sh[0] & 8'h1F, {3'h0, port2_latch});
    chk_pin("port6_latch", sh[1] & 8'h03, {6'h0, port6_latch});
    chk_pin("port7_latch", sh[2] & 8'h01, {7'h0, port7_latch});
    chk_pin("port12_latch", sh[3] & 8'h07, {5'h0, port12_latch});
    chk_pin("port2_dir", sh[4] & 8'h1F, {3'h0, port2_direction});
    chk_pin("port4_dir", sh[5] & 8'h03, {6'h0, port4_direction});
    chk_pin("port6_dir", sh[6] & 8'h0F, {4'h0, port6_direction});
    chk_pin("port7_dir", sh[7] & 8'h3F, {2'h0, port7_direction});
    chk_pin("port12_dir", sh[9] & 8'h1F, {3'h0, port12_direction});
    chk_pin("port14_dir", sh[10] & 8'h01, {7'h0, port14_direction});
    chk_pin("port7_pullup", sh[13] & 8'h01, {7'h0, port7_pullup});
    chk_pin("input_sel", (c <= 3'h4) ? 8'(8'h01 << c) : 8'h00,
            {3'h0, analog_input_sel});
    chk_pin("input_valid", {7'h0, c <= 3'h4},
            {7'h0, analog_input_valid});
    chk_pin("analog_pin", (n <= 3'h5) ? 8'(5'(5'h1F << n)) : 8'h1F,
            {3'h0, analog_pin});
  endtask

  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < pcfg_pkg::PCFG_NREG; i++) begin
      sh[i] = pcfg_pkg::PCFG_RST_TABLE[i];
    end
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    print_verdict();
  end

  initial begin
    logic [15:0] gone [3];
    gone = '{16'hFF04, 16'hFF0E, 16'hFF40};
    void'($urandom(67));
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata} = '0;
    {s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
    @(posedge aclk);
    do_reset();
    read_all();
    check_ports();
    for (int c = 0; c < 8; c++) begin
      wr_slot(8, 8'(c));
      check_ports();
    end
    for (int n = 0; n < 8; n++) begin
      wr_slot(11, 8'(n));
      check_ports();
    end
    // ignored bits: all ones then all zeros into every register
    for (int i = 0; i < pcfg_pkg::PCFG_NREG; i++) begin
      wr_slot(i, 8'hFF);
    end
    read_all();
    for (int i = 0; i < pcfg_pkg::PCFG_NREG; i++) begin
      wr_slot(i, 8'h00);
    end
    read_all();
    check_ports();
    for (int k = 0; k < 40; k++) begin
      wr_slot(k % 15, 8'($urandom));
      check_ports();
    end
    for (int j = 0; j < 3; j++) begin
      wr(gone[j], 8'($urandom), 4'hF, pcfg_pkg::PCFG_RESP_SLVERR);
      rd(gone[j], 32'h0, pcfg_pkg::PCFG_RESP_SLVERR);
    end
    // byte lane 0 off: nothing may change
    wr(pcfg_pkg::PCFG_IDX_TABLE[0], 8'($urandom), 4'hE,
       pcfg_pkg::PCFG_RESP_OKAY);
    read_all();
    do_reset();
    read_all();
    check_ports();
    print_verdict();
  end
endmodule
